/* include/l1te_pkg.sv */
// Constants, codes and state type for the layer-1 activation block
package l1te_pkg;
  // Timing figures in their own units and derived cycle counts
  localparam int CLK_NS        = 5;
  localparam int HALF_MS_NS    = 500000;
  localparam int WANDER_HI_NS  = 50000;
  localparam int WANDER_LO_NS  = 25000;
  localparam int TM1_HZ        = 2000;
  localparam int TM2_HZ        = 96000;
  localparam int HALF_MS_CYC   = HALF_MS_NS / CLK_NS;
  localparam int WANDER_HI_CYC = WANDER_HI_NS / CLK_NS;
  localparam int WANDER_LO_CYC = WANDER_LO_NS / CLK_NS;
  localparam int TM1_CYC       = 1000000000 / (TM1_HZ * CLK_NS);
  localparam int TM2_CYC       = 1000000000 / (TM2_HZ * CLK_NS);
  localparam logic [2:0] CVR_REPEATS = 3'h6;
  localparam logic [14:0] SYNC_IDLE = 15'h0100; // Upstream data line idles high

  // Register map and fields
  localparam logic [31:0] CONF_OFF = 32'h0000_0000;
  localparam logic [31:0] STAT_OFF = 32'h0000_0004;
  localparam logic [7:0]  CONF_RST = 8'h80;
  localparam int CF_TRUNK = 0;
  localparam int CF_CSS   = 1;
  localparam int CF_VRE   = 2;
  localparam int CF_WLS   = 3;
  localparam int CF_PRIO  = 4;

  // Commands received on the command channel
  localparam logic [3:0] CMD_TIM  = 4'h0;
  localparam logic [3:0] CMD_RES  = 4'h1;
  localparam logic [3:0] CMD_TM1  = 4'h2;
  localparam logic [3:0] CMD_TM2  = 4'h3;
  localparam logic [3:0] CMD_AR8  = 4'h8;
  localparam logic [3:0] CMD_ACTIVATION_BID_PRIO_LOW = 4'h9;
  localparam logic [3:0] CMD_ARL  = 4'ha;
  localparam logic [3:0] CMD_DI   = 4'hf;

  // Indications sent on the command channel
  localparam logic [3:0] IND_DR   = 4'h0;
  localparam logic [3:0] IND_RES  = 4'h1;
  localparam logic [3:0] IND_TM1  = 4'h2;
  localparam logic [3:0] IND_TM2  = 4'h3;
  localparam logic [3:0] IND_RSY  = 4'h4;
  localparam logic [3:0] IND_SLIP = 4'h5;
  localparam logic [3:0] IND_PU   = 4'h7;
  localparam logic [3:0] IND_AR   = 4'h8;
  localparam logic [3:0] IND_ARL  = 4'ha;
  localparam logic [3:0] IND_CVR  = 4'hb;
  localparam logic [3:0] IND_AI8  = 4'hc;
  localparam logic [3:0] IND_ACTIVE_PRIO_LOW = 4'hd;
  localparam logic [3:0] IND_AIL  = 4'he;
  localparam logic [3:0] IND_DC   = 4'hf;

  // Received line signal codes and transmitted signal codes
  localparam logic [2:0] LI_I0  = 3'h0;
  localparam logic [2:0] LI_I2  = 3'h2;
  localparam logic [2:0] LI_I4  = 3'h4;
  localparam logic [1:0] TX_I0  = 2'h0;
  localparam logic [1:0] TX_I1  = 2'h1;
  localparam logic [1:0] TX_I3  = 2'h2;
  localparam logic [1:0] TX_IT  = 2'h3;

  typedef enum logic [3:0] {
    ST_RESET, ST_PDOWN, ST_PUP, ST_PDEACT, ST_PACT, ST_UNSYNC, ST_SYNCED,
    ST_ACTIVE, ST_SLIP, ST_LOOPC, ST_LOOPA, ST_TEST1, ST_TEST2
  } l1te_state_t;
endpackage : l1te_pkg

/* src/l1te_fsm.sv */
// Layer-1 activation state machine for endpoint and trunk modes
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - Reset pin acts on the state machine exactly like the clear command
// - Trunk mode only: slip event when framing offset exceeds limit
// - Wander limit is 50 us, or 25 us when limit select set
// - Slip while active enters slip state, left after 0.5 ms
// - With reporting enabled, violation indicated for six frames after bad multiframe
// - INFO 4 gives high-priority active for 8/9, low for 10/11
// - Clock request code or low upstream line gives power up, then indication
// - Power down keeps awake detector; endpoint stops clocks only if select set
// - INFO 0 in F5-F8 gives pending deactivation; leave by line or deactivate
// - Pending activation sends INFO 1, shows power up, stays; software times out
// - Line signal stops INFO 1, waits unsynchronised; also on sync loss
// - INFO 2 gives synchronised state, INFO 3 sent, activation bid shown
// - Synchronised becomes activated after 0.5 ms of INFO 4
// - Loop command loops INFO 3 inside, sends INFO 0, shows loop closed
// - Locked loop shows loop active; line signal seen shows resync
// - Test modes send 2 kHz single or 96 kHz continuous pulses, acknowledged
// - Reset state sends INFO 0, awake detector off, clocks kept running
// - Network deactivation over the line gives deactivate request indication
// - Signal seen but receiver not locked gives resync indication
// - Deactivate command enters power down, except in unsynchronised, synchronised, active and slip states; clocks stop only in endpoint mode with select set
// - Clear command sends INFO 0 and ignores line signals in any state
module l1te_fsm
  import l1te_pkg::*;
#(
  parameter int HALF_MS_P = HALF_MS_CYC,
  parameter int WANDER_HI_P = WANDER_HI_CYC,
  parameter int WANDER_LO_P = WANDER_LO_CYC,
  parameter int TM1_P = TM1_CYC
)(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        iom_bit_clock_in,
  input  wire logic        frame_sync_in,
  input  wire logic [3:0]  ci_cmd_in,
  input  wire logic        upstream_data_line_in,
  input  wire logic        hw_reset_in,
  input  wire logic [2:0]  line_info_in,
  input  wire logic        rx_locked_in,
  input  wire logic        code_viol_in,
  input  wire logic        multiframe_in,
  input  wire logic        line_frame_in,
  output logic      [3:0]  ci_ind_out,
  output logic             ind_strobe_out,
  output logic      [1:0]  tx_info_out,
  output logic             pulse_pos_out,
  output logic             pulse_neg_out,
  output logic             loop_closed_out,
  output logic             iface_clk_en_out,
  output logic             awake_det_en_out,
  output logic             slip_out
);
  logic [14:0] s1, s2;
  logic [4:0]  eq;
  logic        bclk, fs, du, hwr, locked, cv, mf, lfr;
  logic [3:0]  cmd;
  logic [2:0]  info;
  logic        fs_rise, bclk_rise, mf_rise, lfr_rise, cv_rise;
  logic        tim, di, ar, lvl, i0, slip_ev, tmr_done;
  l1te_state_t st, next_st;
  logic [16:0] tmr, next_tmr, tcnt, next_tcnt;
  logic        pol, next_pol, bseen, next_bseen;
  logic [15:0] offc, next_offc, refo, next_refo, diff;
  logic        refv, next_refv, vseen, next_vseen;
  logic [2:0]  far_code_violation, next_cvr;
  logic [3:0]  ind_now, next_ind;
  logic [1:0]  next_tx;
  logic        next_pos, next_neg, next_clken;
  logic [7:0]  conf, next_conf;
  logic        ap_v, ap_w, next_ap_v, next_ap_w;
  logic [31:0] ap_a, next_ap_a, next_rdata;

  // Two-stage synchroniser for every pin from the link side
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s1 <= SYNC_IDLE; // Idle pin levels, so no false clock request
      s2 <= SYNC_IDLE;
      eq <= 5'h0;
    end
    else
    begin
      s1 <= {iom_bit_clock_in, frame_sync_in, ci_cmd_in, upstream_data_line_in,
             hw_reset_in, line_info_in, rx_locked_in, code_viol_in,
             multiframe_in, line_frame_in};
      s2 <= s1;
      eq <= {s2[14], s2[13], s2[2], s2[1], s2[0]};
    end
  end

  // Field split and edge finding on the synchronised pins
  assign {bclk, fs, cmd, du, hwr, info, locked, cv, mf, lfr} = s2;
  assign bclk_rise = bclk & ~eq[4];
  assign fs_rise   = fs & ~eq[3];
  assign cv_rise   = cv & ~eq[2];
  assign mf_rise   = mf & ~eq[1];
  assign lfr_rise  = lfr & ~eq[0];

  // Command decode, taken once per frame; low upstream line asks for clocks
  assign tim = (fs_rise && cmd == CMD_TIM) || !du;
  assign di  = fs_rise && cmd == CMD_DI;
  assign ar  = fs_rise && (cmd == CMD_AR8 || cmd == CMD_ACTIVATION_BID_PRIO_LOW);
  assign lvl = info != LI_I0;
  assign i0  = info == LI_I0;
  assign tmr_done = 32'(tmr) >= HALF_MS_P - 1;

  // Wander between line frame and interface frame against the limit
  assign diff = (offc >= refo) ? offc - refo : refo - offc;
  assign slip_ev = lfr_rise && refv && conf[CF_TRUNK] && st == ST_ACTIVE &&
                   32'(diff) > (conf[CF_WLS] ? WANDER_LO_P : WANDER_HI_P);

  // Next state of the activation machine
  always_comb
  begin
    next_st = st;
    if (hwr)
      next_st = ST_RESET;
    else if (fs_rise && cmd == CMD_RES)
      next_st = ST_RESET;
    else if (fs_rise && cmd == CMD_ARL)
      next_st = ST_LOOPC;
    else if (fs_rise && cmd == CMD_TM1)
      next_st = ST_TEST1;
    else if (fs_rise && cmd == CMD_TM2)
      next_st = ST_TEST2;
    else
    begin
      case (st)
        ST_RESET:
          if (tim) next_st = ST_PUP;
          else if (di) next_st = ST_PDOWN;
          else if (ar) next_st = ST_PACT;
        ST_PDOWN:
          if (lvl) next_st = ST_UNSYNC;
          else if (ar) next_st = ST_PACT;
          else if (tim) next_st = ST_PUP;
        ST_PUP:
          if (lvl) next_st = ST_UNSYNC;
          else if (ar) next_st = ST_PACT;
          else if (di) next_st = ST_PDOWN;
        // leave by line or deactivate, or by the clear, loop or test commands decoded above
        ST_PDEACT, ST_PACT:
          if (lvl) next_st = ST_UNSYNC;
          else if (di) next_st = ST_PDOWN;
        ST_UNSYNC:
          if (i0) next_st = ST_PDEACT;
          else if (locked && info == LI_I4) next_st = ST_ACTIVE;
          else if (locked && info == LI_I2) next_st = ST_SYNCED;
        // INFO 4 held for 0.5 ms
        ST_SYNCED:
          if (i0) next_st = ST_PDEACT;
          else if (!locked) next_st = ST_UNSYNC;
          else if (tmr_done) next_st = ST_ACTIVE;
        ST_ACTIVE:
          if (i0) next_st = ST_PDEACT;
          else if (!locked) next_st = ST_UNSYNC;
          else if (slip_ev) next_st = ST_SLIP;
        ST_SLIP:
          if (i0) next_st = ST_PDEACT;
          else if (tmr_done) next_st = ST_ACTIVE;
        // loop locks on looped INFO 3
        ST_LOOPC:
          if (locked) next_st = ST_LOOPA;
          else if (di) next_st = ST_PDOWN;
        ST_LOOPA, ST_TEST1, ST_TEST2:
          if (di) next_st = ST_PDOWN;
        default:
          next_st = ST_RESET;
      endcase
    end
  end

  // Indication for the present state
  always_comb
  begin
    case (st)
      ST_RESET:  ind_now = IND_RES;
      ST_PDOWN:  ind_now = IND_DC;
      ST_PUP:    ind_now = bseen ? IND_PU : IND_DC;
      ST_PDEACT: ind_now = IND_DR;
      ST_PACT:   ind_now = IND_PU;
      ST_UNSYNC: ind_now = IND_RSY;
      ST_SYNCED: ind_now = IND_AR;
      ST_ACTIVE:
        if (far_code_violation != 3'h0) ind_now = IND_CVR;
        else if (conf[CF_PRIO+3:CF_PRIO+1] == 3'h4) ind_now = IND_AI8;
        else ind_now = IND_ACTIVE_PRIO_LOW;
      ST_SLIP:   ind_now = IND_SLIP;
      ST_LOOPC:  ind_now = IND_ARL;
      ST_LOOPA:  ind_now = lvl ? IND_RSY : IND_AIL;
      ST_TEST1:  ind_now = IND_TM1;
      ST_TEST2:  ind_now = IND_TM2;
      default:   ind_now = IND_RES;
    endcase
  end

  // Timers, pulse generator, wander and violation tracking, outputs
  always_comb
  begin
    next_tmr = (next_st != st || (st == ST_SYNCED && info != LI_I4)) ? 17'h0 : tmr + 17'h1;
    next_tcnt = 17'h0;
    next_pol = pol;
    if (st == ST_TEST1 || st == ST_TEST2)
    begin
      next_tcnt = tcnt + 17'h1;
      if (32'(tcnt) >= (st == ST_TEST1 ? TM1_P : TM2_CYC) - 1)
      begin
        next_tcnt = 17'h0;
        next_pol = ~pol;
      end
    end
    next_pos = (st == ST_TEST2 || (st == ST_TEST1 && 32'(tcnt) < TM2_CYC)) && pol;
    next_neg = (st == ST_TEST2 || (st == ST_TEST1 && 32'(tcnt) < TM2_CYC)) && !pol;
    next_offc = fs_rise ? 16'h0 : (&offc ? offc : offc + 16'h1);
    next_refv = refv;
    next_refo = refo;
    if ((st != ST_ACTIVE && st != ST_SLIP) || slip_ev)
      next_refv = 1'b0;
    else if (lfr_rise && !refv)
    begin
      next_refv = 1'b1;
      next_refo = offc;
    end
    // six violation reports per bad multiframe
    next_vseen = cv_rise | (vseen & ~mf_rise);
    next_cvr = far_code_violation;
    if (mf_rise && (vseen || cv_rise) && conf[CF_VRE])
      next_cvr = CVR_REPEATS;
    else if (fs_rise && far_code_violation != 3'h0)
      next_cvr = far_code_violation - 3'h1;
    next_ind = fs_rise ? ind_now : ci_ind_out;
    case (next_st)
      ST_PACT: next_tx = TX_I1;
      ST_SYNCED, ST_ACTIVE, ST_SLIP: next_tx = TX_I3;
      ST_TEST1, ST_TEST2: next_tx = TX_IT;
      default: next_tx = TX_I0;
    endcase
    // clocks stop only with select set
    next_clken = !(next_st == ST_PDOWN && !conf[CF_TRUNK] && conf[CF_CSS]);
    next_bseen = iface_clk_en_out && (bseen || bclk_rise);
  end

  // Bus slave address and data phase
  always_comb
  begin
    next_ap_v = hsel_in && hready_in && htrans_in[1];
    next_ap_w = hwrite_in;
    next_ap_a = haddr_in;
    next_conf = (ap_v && ap_w && ap_a == CONF_OFF) ? hwdata_in[7:0] : conf;
    next_rdata = 32'h0;
    if (next_ap_v && !hwrite_in && haddr_in == CONF_OFF)
      next_rdata = {24'h0, conf};
    else if (next_ap_v && !hwrite_in && haddr_in == STAT_OFF)
      next_rdata = {20'h0, loop_closed_out, iface_clk_en_out, tx_info_out,
                    ci_ind_out, 4'(st)};
  end

  // Register every group of state
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st <= ST_RESET;
      tmr <= 17'h0;
      tcnt <= 17'h0;
      pol <= 1'b0;
      bseen <= 1'b0;
      offc <= 16'h0;
      refo <= 16'h0;
      refv <= 1'b0;
      vseen <= 1'b0;
      far_code_violation <= 3'h0;
      conf <= CONF_RST;
      ap_v <= 1'b0;
      ap_w <= 1'b0;
      ap_a <= 32'h0;
      hrdata_out <= 32'h0;
      ci_ind_out <= IND_RES;
      ind_strobe_out <= 1'b0;
      tx_info_out <= TX_I0;
      pulse_pos_out <= 1'b0;
      pulse_neg_out <= 1'b0;
      loop_closed_out <= 1'b0;
      iface_clk_en_out <= 1'b1;
      awake_det_en_out <= 1'b0;
      slip_out <= 1'b0;
    end
    else
    begin
      st <= next_st;
      tmr <= next_tmr;
      tcnt <= next_tcnt;
      pol <= next_pol;
      bseen <= next_bseen;
      offc <= next_offc;
      refo <= next_refo;
      refv <= next_refv;
      vseen <= next_vseen;
      far_code_violation <= next_cvr;
      conf <= next_conf;
      ap_v <= next_ap_v;
      ap_w <= next_ap_w;
      ap_a <= next_ap_a;
      hrdata_out <= next_rdata;
      ci_ind_out <= next_ind;
      ind_strobe_out <= fs_rise;
      tx_info_out <= next_tx;
      pulse_pos_out <= next_pos;
      pulse_neg_out <= next_neg;
      loop_closed_out <= next_st == ST_LOOPC || next_st == ST_LOOPA;
      iface_clk_en_out <= next_clken;
      awake_det_en_out <= next_st != ST_RESET;
      slip_out <= slip_ev;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_got_i2;
    st == ST_UNSYNC && info == LI_I2 && locked && !hwr && !fs_rise;
  endsequence
  sequence s_synced_i3;
    st == ST_SYNCED ##0 tx_info_out == TX_I3;
  endsequence

  a_reset_entry: assert property (hwr |=> st == ST_RESET ##1 !awake_det_en_out)
    else $error("pin reset did not clear state");
  a_reset_quiet: assert property (st == ST_RESET |-> tx_info_out == TX_I0 && iface_clk_en_out)
    else $error("reset state not quiet");
  a_slip_trunk: assert property (slip_out |-> $past(conf[CF_TRUNK]) && st == ST_SLIP)
    else $error("slip outside trunk active");
  a_slip_leave: assert property (st == ST_SLIP && tmr_done && !i0 && !hwr && !fs_rise
                                 |=> st == ST_ACTIVE)
    else $error("slip state not left");
  a_cvr_load: assert property (mf_rise && vseen && conf[CF_VRE] |=> far_code_violation == 3'h6)
    else $error("violation repeat not loaded");
  a_prio_high: assert property (st == ST_ACTIVE && far_code_violation == 3'h0 && fs_rise && !hwr &&
                                conf[7:5] == 3'h4 |=> ci_ind_out == IND_AI8)
    else $error("high priority active missing");
  a_clock_stop: assert property (st == ST_PDOWN && !conf[CF_TRUNK] && conf[CF_CSS]
                                 |-> !iface_clk_en_out)
    else $error("clocks not stopped");
  a_pend_deact: assert property (st == ST_ACTIVE && i0 && !hwr && !fs_rise
                                 |=> st == ST_PDEACT ##1 tx_info_out == TX_I0)
    else $error("no pending deactivation");
  a_pend_act_tx: assert property (st == ST_PACT |-> tx_info_out == TX_I1)
    else $error("pending activation not sending INFO 1");
  a_sync_step: assert property (s_got_i2 |=> s_synced_i3)
    else $error("INFO 2 did not synchronise");
  a_test2_run: assert property (st == ST_TEST2 ##1 st == ST_TEST2
                                |-> pulse_pos_out != pulse_neg_out)
    else $error("continuous pulses missing");
endmodule : l1te_fsm

/* tb/l1te_nt_model.sv */
// Network termination model standing on the line side of the layer-1 block
`timescale 1ns/1ps
module l1te_nt_model
  import l1te_pkg::*;
#(
  parameter int LOCK_DLY = 600,
  parameter int I4_DLY   = 600
)(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       present_in,
  input  wire logic       viol_in,
  input  wire logic [1:0] tx_info_in,
  input  wire logic       loop_closed_in,
  output logic      [2:0] line_info_out,
  output logic            rx_locked_out,
  output logic            code_viol_out,
  output logic            multiframe_out,
  output logic            line_frame_out
);
  int          lock_cnt;
  int          i3_cnt;
  logic [10:0] fr_cnt;

  // Lock and answer timers; slow enough that every step shows for a frame
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      lock_cnt <= 0;
      i3_cnt   <= 0;
      fr_cnt   <= 11'h000;
    end
    else
    begin
      lock_cnt <= (present_in || loop_closed_in) ? lock_cnt + int'(lock_cnt < LOCK_DLY) : 0;
      i3_cnt   <= (present_in && tx_info_in == TX_I3) ? i3_cnt + int'(i3_cnt < I4_DLY) : 0;
      fr_cnt   <= (fr_cnt == 11'h4ff) ? 11'h000 : fr_cnt + 11'h001;
    end
  end

  // Absent network sends INFO 0; present one sends INFO 2, then INFO 4 to INFO 3
  always_comb
  begin
    line_info_out  = !present_in ? LI_I0 : (i3_cnt >= I4_DLY ? LI_I4 : LI_I2);
    rx_locked_out  = lock_cnt >= LOCK_DLY;
    line_frame_out = fr_cnt[5:0] == 6'h00;
    multiframe_out = fr_cnt == 11'h000;
    code_viol_out  = viol_in && fr_cnt[5:0] == 6'h10;
  end
endmodule : l1te_nt_model

/* tb/tb_layer1_te_activation_fsm.sv */
// Self-checking bench for the layer-1 activation state machine
`timescale 1ns/1ps
module tb_layer1_te_activation_fsm;
  import l1te_pkg::*;
  localparam int         HMS = 50;
  localparam logic [3:0] NOP = 4'h7;
  logic        ref_clk_in, reset_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0]  htrans_in, tx_info_out;
  logic [2:0]  hsize_in, line_info_in;
  logic [3:0]  ci_cmd_in, ci_ind_out, bit_cnt;
  logic        iom_bit_clock_in, frame_sync_in, upstream_data_line_in, hw_reset_in;
  logic        rx_locked_in, code_viol_in, multiframe_in, line_frame_in, ind_strobe_out;
  logic        pulse_pos_out, pulse_neg_out, loop_closed_out, iface_clk_en_out;
  logic        awake_det_en_out, slip_out, present, viol;
  int          n_errors, comparisons, cyc;

  l1te_fsm #(.HALF_MS_P(HMS), .WANDER_HI_P(40), .WANDER_LO_P(20), .TM1_P(4000)) i_l1te_fsm (
    .ref_clk_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
    .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
    .iom_bit_clock_in, .frame_sync_in, .ci_cmd_in, .upstream_data_line_in, .hw_reset_in,
    .line_info_in, .rx_locked_in, .code_viol_in, .multiframe_in, .line_frame_in,
    .ci_ind_out, .ind_strobe_out, .tx_info_out, .pulse_pos_out, .pulse_neg_out,
    .loop_closed_out, .iface_clk_en_out, .awake_det_en_out, .slip_out);

  l1te_nt_model i_l1te_nt_model (
    .ref_clk_in, .reset_n_in, .present_in(present), .viol_in(viol), .tx_info_in(tx_info_out),
    .loop_closed_in(loop_closed_out), .line_info_out(line_info_in),
    .rx_locked_out(rx_locked_in), .code_viol_out(code_viol_in),
    .multiframe_out(multiframe_in), .line_frame_out(line_frame_in));

  // System clock, 5 ns period
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // Bit clock at 160 ns, unrelated phase, kept running through reset
  initial
  begin
    iom_bit_clock_in = 1'b0;
    #37;
    forever #80 iom_bit_clock_in = ~iom_bit_clock_in;
  end

  // Frame sync once every eight bit clocks
  always @(posedge iom_bit_clock_in)
  begin
    bit_cnt       <= bit_cnt + 4'h1;
    frame_sync_in <= (bit_cnt[2:0] == 3'h7);
  end

  // Hang guard
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      $display("BAD timeout expected 0 seen %0d", cyc);
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One single AHB-Lite transfer, held until the slave is ready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_in   <= 1'b1;
    haddr_in  <= a;
    hwrite_in <= wr;
    htrans_in <= 2'h2;
    @(posedge ref_clk_in);
    while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    @(posedge ref_clk_in);
    while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
    rd = hrdata_out;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
                        input string nm);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk(nm, e, d & m);
  endtask : rd_chk

  task automatic wait_ind(input logic [3:0] e, input string nm);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    while (ci_ind_out !== e && n < 3000)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(nm, e, ci_ind_out);
  endtask : wait_ind

  task automatic do_cmd(input logic [3:0] c, input logic [3:0] e, input string nm);
    ci_cmd_in <= c;
    wait_ind(e, nm);
    ci_cmd_in <= NOP;
  endtask : do_cmd

  task automatic pulses(input int n, input string nm);
    logic p, q;
    p = 1'b0;
    q = 1'b0;
    repeat (n)
    begin
      @(posedge ref_clk_in);
      p |= (pulse_pos_out === 1'b1);
      q |= (pulse_neg_out === 1'b1);
    end
    chk(nm, 2'b11, {p, q});
  endtask : pulses

  task automatic t_reset;
    chk("tx", TX_I0, tx_info_out);
    chk("awake", 1'b0, awake_det_en_out);
    chk("clk_en", 1'b1, iface_clk_en_out);
    chk("hresp", 1'b0, hresp_out);
    rd_chk(CONF_OFF, 32'h80, 32'hff, "conf");
    wr(32'h10, 32'hff);
    wr(STAT_OFF, 32'hff);
    rd_chk(32'h10, 32'h0, 32'hffffffff, "unmapped");
    rd_chk(STAT_OFF, ST_RESET, 32'hf, "state");
    rd_chk(CONF_OFF, 32'h80, 32'hff, "conf kept");
    $display("test reset done");
  endtask : t_reset

  task automatic t_power;
    do_cmd(CMD_TIM, IND_PU, "pu");
    rd_chk(STAT_OFF, ST_PUP, 32'hf, "state pup");
    do_cmd(CMD_DI, IND_DC, "dc");
    chk("clk kept", 1'b1, iface_clk_en_out);
    chk("awake on", 1'b1, awake_det_en_out);
    upstream_data_line_in <= 1'b0;
    wait_ind(IND_PU, "pu line");
    upstream_data_line_in <= 1'b1;
    wr(CONF_OFF, 32'h82);
    do_cmd(CMD_DI, IND_DC, "dc stop");
    repeat (1100) @(posedge ref_clk_in);
    chk("clk stop", 1'b0, iface_clk_en_out);
    $display("test power done");
  endtask : t_power

  task automatic t_act(input logic [31:0] conf, input logic [3:0] c, input logic [3:0] ai);
    int t;
    wr(CONF_OFF, conf);
    do_cmd(c, IND_PU, "pend pu");
    t = 0;
    repeat (800)
    begin
      @(posedge ref_clk_in);
      t += int'(ind_strobe_out === 1'b1);
    end
    chk("repeat", 1'b1, t >= 3);
    chk("pend tx", TX_I1, tx_info_out);
    chk("pend ind", IND_PU, ci_ind_out);
    present <= 1'b1;
    wait_ind(IND_RSY, "unsync");
    wait_ind(IND_AR, "ar");
    chk("tx i3", TX_I3, tx_info_out);
    t = 0;
    while (line_info_in !== LI_I4 && t < 2000)
    begin
      @(posedge ref_clk_in);
      t++;
    end
    repeat (HMS - 10) @(posedge ref_clk_in);
    rd_chk(STAT_OFF, ST_SYNCED, 32'hf, "still synced");
    wait_ind(ai, "active");
    $display("test activate done");
  endtask : t_act

  task automatic t_deact;
    present <= 1'b0;
    wait_ind(IND_DR, "dr");
    rd_chk(STAT_OFF, ST_PDEACT, 32'hf, "pdeact");
    ci_cmd_in <= CMD_AR8;
    repeat (600) @(posedge ref_clk_in);
    ci_cmd_in <= NOP;
    rd_chk(STAT_OFF, ST_PDEACT, 32'hf, "no reactivate");
    do_cmd(CMD_DI, IND_DC, "dc after");
    $display("test deactivate done");
  endtask : t_deact

  task automatic t_events;
    int s;
    wr(CONF_OFF, 32'ha4);
    viol <= 1'b1;
    wait_ind(IND_CVR, "cvr");
    viol <= 1'b0;
    wr(CONF_OFF, 32'ha1);
    s = 0;
    repeat (600)
    begin
      @(posedge ref_clk_in);
      s += int'(slip_out === 1'b1);
    end
    chk("slip trunk", 1'b1, s > 0);
    wr(CONF_OFF, 32'ha0);
    wait_ind(IND_ACTIVE_PRIO_LOW, "after slip");
    s = 0;
    repeat (600)
    begin
      @(posedge ref_clk_in);
      s += int'(slip_out === 1'b1);
    end
    chk("slip endpoint", 32'h0, s);
    $display("test events done");
  endtask : t_events

  task automatic t_clear;
    do_cmd(CMD_RES, IND_RES, "res");
    repeat (600) @(posedge ref_clk_in);
    rd_chk(STAT_OFF, ST_RESET, 32'hf, "res stays");
    chk("res tx", TX_I0, tx_info_out);
    chk("res awake", 1'b0, awake_det_en_out);
    present <= 1'b0;
    $display("test clear done");
  endtask : t_clear

  task automatic t_loop;
    do_cmd(CMD_ARL, IND_ARL, "arl");
    chk("loop", 1'b1, loop_closed_out);
    chk("loop tx", TX_I0, tx_info_out);
    wait_ind(IND_AIL, "ail");
    present <= 1'b1;
    wait_ind(IND_RSY, "loop rsy");
    present <= 1'b0;
    $display("test loop done");
  endtask : t_loop

  task automatic t_test;
    do_cmd(CMD_TM1, IND_TM1, "tm1");
    chk("tm tx", TX_IT, tx_info_out);
    pulses(9000, "tm1 pulses");
    do_cmd(CMD_TM2, IND_TM2, "tm2");
    pulses(4600, "tm2 pulses");
    $display("test pulses done");
  endtask : t_test

  task automatic t_pin;
    hw_reset_in <= 1'b1;
    repeat (64) @(posedge ref_clk_in);
    hw_reset_in <= 1'b0;
    wait_ind(IND_RES, "pin res");
    rd_chk(STAT_OFF, ST_RESET, 32'hf, "pin state");
    chk("pin tx", TX_I0, tx_info_out);
    $display("test pin reset done");
  endtask : t_pin

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    {reset_n_in, hsel_in, hwrite_in, hw_reset_in, present, viol} = 6'h00;
    {haddr_in, hwdata_in, htrans_in, hsize_in} = {32'h0, 32'h0, 2'h0, 3'h2};
    {ci_cmd_in, upstream_data_line_in, bit_cnt, frame_sync_in} = {NOP, 1'b1, 4'h0, 1'b0};
    {n_errors, comparisons, cyc} = {32'd0, 32'd0, 32'd0};
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    t_reset();
    t_power();
    t_act(32'h80, CMD_AR8, IND_AI8);
    t_deact();
    t_act(32'ha0, CMD_ACTIVATION_BID_PRIO_LOW, IND_ACTIVE_PRIO_LOW);
    t_events();
    t_clear();
    t_loop();
    t_test();
    t_pin();
    tally_and_finish();
  end
endmodule : tb_layer1_te_activation_fsm
